// [hw/nec_defs.svh]
// constants for the erase command sequencer
//
// Behaviour
// - six writes 80/10h launch chip erase
// - protected blocks skipped, no error raised
// - chip erase ignores every command, suspend too
// - reads during chip erase return polling
// - chip erase: pass to read, fail holds
// - unprotected blocks all erased to ones
// - reset aborts erase; host repeats it
// - bypass chip erase takes two writes
// - block erase 80/30h; repeat sixth adds
// - other command in window, bar suspend, cancels erase
// - window expiry shown on polling bit
// - timer restarts per block; closes after
// - reads after sixth write return polling
// - block erase: done to read, error holds
// - protected selected blocks skipped silently
// - block erase accepts only suspend, not reset
// - bypass block erase two writes, repeatable
// - suspend is one B0h write, any address
// - suspend halts erase; window ends at once
// - suspended: reads, bypass still allowed; reset ignored
// - reads of suspended block give polling
// - resume 30h only in read array mode
`ifndef NEC_DEFS_SVH
`define NEC_DEFS_SVH
// ****************************************
// bus shape
// ****************************************
`define NEC_AW 24
`define NEC_DW 8
`define NEC_UAW 12
`define NEC_NBLK 16
`define NEC_BLK_W 4
`define NEC_BLK_LSB 20
// ****************************************
// command codes and unlock addresses
// ****************************************
`define NEC_CD_UNLK1 8'hAA
`define NEC_CD_UNLK2 8'h55
`define NEC_CD_SETUP 8'h80
`define NEC_CD_CHIP 8'h10
`define NEC_CD_BLOCK 8'h30
`define NEC_CD_RESUME 8'h30
`define NEC_CD_SUSP 8'hB0
`define NEC_CD_RESET 8'hF0
`define NEC_CD_BYP 8'h20
`define NEC_CD_BYPX1 8'h90
`define NEC_CD_BYPX2 8'h00
`define NEC_AD_UNLK1 12'h555
`define NEC_AD_UNLK2 12'h2AA
// ****************************************
// decoder steps and polling bits
// ****************************************
`define NEC_STP_IDLE 3'h0
`define NEC_STP_U2 3'h1
`define NEC_STP_CMD 3'h2
`define NEC_STP_U3 3'h3
`define NEC_STP_U4 3'h4
`define NEC_STP_LAST 3'h5
`define NEC_STP_BX 3'h6
`define NEC_SB_DONE 7
`define NEC_SB_TOG 6
`define NEC_SB_FAIL 5
`define NEC_SB_WIN 3
`define NEC_SB_STOG 2
// ****************************************
// selection window timing
// ****************************************
`define NEC_CLK_NS 40
`define NEC_WIN_NS 50000
`define NEC_WIN_CYC ((`NEC_WIN_NS + `NEC_CLK_NS - 1) / `NEC_CLK_NS)
`define NEC_WIN_CW 11
`endif

// [hw/nec_pkg.sv]
// types shared by both ends of the erase sequencer
package nec_pkg;
  // device operation state
  typedef enum logic [2:0] {
    NEC_READ, NEC_WINDOW, NEC_ERASE, NEC_CHIP, NEC_SUSP, NEC_ERR
  } nec_state_e;
  // host user commands
  typedef enum logic [3:0] {
    NEC_C_CHIP, NEC_C_BLOCK, NEC_C_ADD, NEC_C_SUSP, NEC_C_RESUME,
    NEC_C_RESET, NEC_C_BYP_ON, NEC_C_BYP_OFF, NEC_C_READ
  } nec_cmd_e;
  // host sequencing state
  typedef enum logic [1:0] {NEC_H_IDLE, NEC_H_WR, NEC_H_RD} nec_hstate_e;
endpackage

// [hw/nec_bus_if.sv]
// parallel bus between host and flash sequencer
`timescale 1ns/1ps
`include "nec_defs.svh"
interface nec_bus_if (
  input wire logic clk,
  input wire logic rst_b
);
  logic we;
  logic re;
  logic [`NEC_AW-1:0] addr;
  logic [`NEC_DW-1:0] wdata;
  logic [`NEC_DW-1:0] rdata;
  logic rvalid;
  modport dev (
    input we, re, addr, wdata,
    output rdata, rvalid
  );
  modport host (
    output we, re, addr, wdata,
    input rdata, rvalid
  );
endinterface

// [hw/nec_timer.sv]
// reloadable down counter giving a one-cycle expiry pulse
`timescale 1ns/1ps
module nec_timer #(
  parameter int CW = 11,
  parameter logic [CW-1:0] LOAD = '1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic stop,
  output logic expire
);
  logic [CW-1:0] cnt_q;
  logic run_q;
  wire last = run_q && (cnt_q == CW'(1));
  // load wins over stop so a restart is never lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= last && !load && !stop;
      if (load) begin
        cnt_q <= LOAD;
        run_q <= 1'b1;
      end else if (stop || last) begin
        run_q <= 1'b0;
        cnt_q <= '0;
      end else if (run_q) begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end
endmodule

// [hw/nec_device.sv]
// flash end: decodes erase commands and steers the erase controller
`timescale 1ns/1ps
`include "nec_defs.svh"
module nec_device
  import nec_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  nec_bus_if.dev BUS,
  input wire logic [`NEC_NBLK-1:0] BLK_PROT,
  input wire logic [`NEC_DW-1:0] ARRAY_DQ,
  input wire logic PEC_DONE,
  input wire logic PEC_FAIL,
  input wire logic PEC_HALTED,
  output logic PEC_START,
  output logic PEC_CHIP,
  output logic PEC_HALT,
  output logic PEC_RESUME,
  output logic [`NEC_NBLK-1:0] ERASE_MASK,
  output logic BUSY
);
  // ****************************************
  // state
  // ****************************************
  nec_state_e st_q, st_d;
  logic [2:0] stp_q, stp_d;
  logic byp_q, byp_d;
  logic started_q, started_d;
  logic tog_q;
  logic [`NEC_NBLK-1:0] mask_d;
  logic start_d, chip_d, halt_d, resume_d;
  logic ev_chip, ev_blk, tmr_load, tmr_exp;
  logic [`NEC_DW-1:0] rdata_q;
  logic rvalid_q;
  logic [`NEC_DW-1:0] status;

  // ****************************************
  // write decode
  // ****************************************
  wire we = BUS.we;
  wire [`NEC_DW-1:0] wd = BUS.wdata;
  wire [`NEC_UAW-1:0] ua = BUS.addr[`NEC_UAW-1:0];
  wire [`NEC_BLK_W-1:0] blk = BUS.addr[`NEC_BLK_LSB +: `NEC_BLK_W];
  wire [`NEC_NBLK-1:0] blk_bit = `NEC_NBLK'(1) << blk;
  wire is_u1 = (wd == `NEC_CD_UNLK1) && (ua == `NEC_AD_UNLK1);
  wire is_u2 = (wd == `NEC_CD_UNLK2) && (ua == `NEC_AD_UNLK2);
  wire is_susp = we && (wd == `NEC_CD_SUSP);
  wire is_sel = we && (wd == `NEC_CD_BLOCK);
  // the sequence decoder only listens in read or suspended state
  wire dec_en = we && ((st_q == NEC_READ) || (st_q == NEC_SUSP));
  wire sel_ok = (st_q == NEC_READ);
  // new block joins the list unless protected
  wire [`NEC_NBLK-1:0] add_bits = blk_bit & ~BLK_PROT;
  wire [`NEC_NBLK-1:0] chip_bits = ~BLK_PROT;
  wire rd_susp_blk = (st_q == NEC_SUSP) && ERASE_MASK[blk];
  // array data only while idle or outside the suspended blocks
  wire show_stat = (st_q != NEC_READ) && !((st_q == NEC_SUSP) &&
                   !rd_susp_blk);

  // command cycle walker; bypass shortens to setup plus confirm
  always_comb begin
    stp_d = `NEC_STP_IDLE;
    byp_d = byp_q;
    ev_chip = 1'b0;
    ev_blk = 1'b0;
    case (stp_q)
      `NEC_STP_IDLE: begin
        if (byp_q && wd == `NEC_CD_SETUP) begin
          stp_d = `NEC_STP_LAST;
        end else if (byp_q && wd == `NEC_CD_BYPX1) begin
          stp_d = `NEC_STP_BX;
        end else if (is_u1) begin
          stp_d = `NEC_STP_U2;
        end
      end
      `NEC_STP_U2: if (is_u2) stp_d = `NEC_STP_CMD;
      `NEC_STP_CMD: begin
        if (wd == `NEC_CD_SETUP) begin
          stp_d = `NEC_STP_U3;
        end else if (wd == `NEC_CD_BYP) begin
          byp_d = 1'b1;
        end
      end
      `NEC_STP_U3: if (is_u1) stp_d = `NEC_STP_U4;
      `NEC_STP_U4: if (is_u2) stp_d = `NEC_STP_LAST;
      `NEC_STP_LAST: begin
        ev_chip = sel_ok && (wd == `NEC_CD_CHIP) &&
                  (byp_q || ua == `NEC_AD_UNLK1);
        ev_blk = sel_ok && (wd == `NEC_CD_BLOCK);
      end
      `NEC_STP_BX: if (wd == `NEC_CD_BYPX2) byp_d = 1'b0;
      default: stp_d = `NEC_STP_IDLE;
    endcase
  end

  // ****************************************
  // operation state machine
  // ****************************************
  always_comb begin
    st_d = st_q;
    mask_d = ERASE_MASK;
    start_d = 1'b0;
    resume_d = 1'b0;
    chip_d = PEC_CHIP;
    halt_d = PEC_HALT;
    started_d = started_q;
    tmr_load = 1'b0;
    case (st_q)
      NEC_READ: begin
        if (dec_en && ev_chip) begin
          mask_d = chip_bits;
          chip_d = 1'b1;
          // nothing to erase: data stays, no error
          if (chip_bits != '0) begin
            st_d = NEC_CHIP;
            start_d = 1'b1;
            started_d = 1'b1;
          end
        end else if (dec_en && ev_blk) begin
          mask_d = add_bits;
          chip_d = 1'b0;
          started_d = 1'b0;
          st_d = NEC_WINDOW;
          tmr_load = 1'b1;
        end
      end
      NEC_WINDOW: begin
        if (is_sel) begin
          mask_d = ERASE_MASK | add_bits;
          tmr_load = 1'b1;
        end else if (is_susp) begin
          st_d = NEC_SUSP;
        end else if (we) begin
          st_d = NEC_READ;
          mask_d = '0;
        end else if (tmr_exp) begin
          // all selected blocks protected: silently done
          if (ERASE_MASK == '0) begin
            st_d = NEC_READ;
          end else begin
            st_d = NEC_ERASE;
            start_d = 1'b1;
            started_d = 1'b1;
          end
        end
      end
      NEC_ERASE: begin
        // only suspend is heard once the controller runs
        if (is_susp) halt_d = 1'b1;
        if (PEC_FAIL) begin
          st_d = NEC_ERR;
          halt_d = 1'b0;
        end else if (PEC_DONE) begin
          st_d = NEC_READ;
          mask_d = '0;
          halt_d = 1'b0;
        end else if (PEC_HALT && PEC_HALTED) begin
          st_d = NEC_SUSP;
        end
      end
      NEC_CHIP: begin
        // writes have no effect here, suspend included
        if (PEC_FAIL) begin
          st_d = NEC_ERR;
        end else if (PEC_DONE) begin
          st_d = NEC_READ;
          mask_d = '0;
        end
      end
      NEC_SUSP: begin
        // resume only from plain read array mode
        if (dec_en && stp_q == `NEC_STP_IDLE && !byp_q &&
            wd == `NEC_CD_RESUME) begin
          st_d = NEC_ERASE;
          halt_d = 1'b0;
          started_d = 1'b1;
          start_d = !started_q;
          resume_d = started_q;
        end
      end
      NEC_ERR: begin
        if (we && wd == `NEC_CD_RESET) begin
          st_d = NEC_READ;
          mask_d = '0;
        end
      end
      default: st_d = NEC_READ;
    endcase
  end

  // selection window timer
  nec_timer #(
    .CW(`NEC_WIN_CW),
    .LOAD(`NEC_WIN_CW'(`NEC_WIN_CYC))
  ) u_win (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .load(tmr_load),
    .stop(st_q == NEC_WINDOW && st_d != NEC_WINDOW),
    .expire(tmr_exp)
  );

  // ****************************************
  // polling register
  // ****************************************
  always_comb begin
    status = '0;
    status[`NEC_SB_DONE] = (st_q == NEC_SUSP);
    status[`NEC_SB_TOG] = tog_q && (st_q != NEC_SUSP);
    status[`NEC_SB_FAIL] = (st_q == NEC_ERR);
    status[`NEC_SB_WIN] = (st_q != NEC_WINDOW);
    status[`NEC_SB_STOG] = tog_q;
  end

  // ****************************************
  // registers; a hardware reset abandons any erase
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= NEC_READ;
      stp_q <= `NEC_STP_IDLE;
      byp_q <= 1'b0;
      started_q <= 1'b0;
      ERASE_MASK <= '0;
      PEC_START <= 1'b0;
      PEC_CHIP <= 1'b0;
      PEC_HALT <= 1'b0;
      PEC_RESUME <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      st_q <= st_d;
      if (dec_en) stp_q <= stp_d;
      else if (st_q != NEC_SUSP) stp_q <= `NEC_STP_IDLE;
      if (dec_en) byp_q <= byp_d;
      started_q <= started_d;
      ERASE_MASK <= mask_d;
      PEC_START <= start_d;
      PEC_CHIP <= chip_d;
      PEC_HALT <= halt_d;
      PEC_RESUME <= resume_d;
      BUSY <= (st_d != NEC_READ);
    end
  end

  // read port: one cycle latency, toggle flips per status read
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      rvalid_q <= BUS.re;
      if (BUS.re) rdata_q <= show_stat ? status : ARRAY_DQ;
      if (BUS.re && show_stat) tog_q <= !tog_q;
    end
  end

  assign BUS.rdata = rdata_q;
  assign BUS.rvalid = rvalid_q;
endmodule

// [hw/nec_host.sv]
// host end: expands user commands into bus write sequences
`timescale 1ns/1ps
`include "nec_defs.svh"
module nec_host
  import nec_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  nec_bus_if.host BUS,
  input wire logic [3:0] CMD,
  input wire logic [`NEC_AW-1:0] CMD_ADDR,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  output logic [`NEC_DW-1:0] RD_DATA,
  output logic RD_VALID,
  output logic BYPASS
);
  nec_hstate_e st_q;
  nec_cmd_e cmd_q;
  logic [`NEC_AW-1:0] a_q;
  logic [2:0] idx_q, len_q;
  logic we_q, re_q;
  logic [`NEC_AW-1:0] addr_q;
  logic [`NEC_DW-1:0] wd_q;
  wire nec_cmd_e cmd_in = nec_cmd_e'(CMD);

  // number of writes per command; bypass cuts erase to two
  function automatic logic [2:0] seq_len(nec_cmd_e c, logic byp);
    case (c)
      NEC_C_CHIP, NEC_C_BLOCK: seq_len = byp ? 3'h2 : 3'h6;
      NEC_C_BYP_ON: seq_len = 3'h3;
      NEC_C_BYP_OFF: seq_len = 3'h2;
      default: seq_len = 3'h1;
    endcase
  endfunction

  // address and data of write number i
  function automatic logic [`NEC_AW+`NEC_DW-1:0] step(
    nec_cmd_e c, logic byp, logic [2:0] i, logic [`NEC_AW-1:0] a);
    logic [2:0] k;
    logic [`NEC_AW-1:0] u1;
    logic [`NEC_AW-1:0] u2;
    k = (byp && i == `NEC_STP_IDLE) ? `NEC_STP_CMD :
        (byp ? `NEC_STP_LAST : i);
    u1 = `NEC_AW'(`NEC_AD_UNLK1);
    u2 = `NEC_AW'(`NEC_AD_UNLK2);
    case (c)
      NEC_C_ADD: step = {a, `NEC_CD_BLOCK};
      NEC_C_SUSP: step = {a, `NEC_CD_SUSP};
      NEC_C_RESUME: step = {a, `NEC_CD_RESUME};
      NEC_C_RESET: step = {a, `NEC_CD_RESET};
      NEC_C_BYP_OFF:
        step = {a, (i == `NEC_STP_IDLE) ? `NEC_CD_BYPX1 : `NEC_CD_BYPX2};
      default: begin
        case (k)
          `NEC_STP_IDLE, `NEC_STP_U3: step = {u1, `NEC_CD_UNLK1};
          `NEC_STP_U2, `NEC_STP_U4: step = {u2, `NEC_CD_UNLK2};
          `NEC_STP_CMD: step = {u1, (c == NEC_C_BYP_ON) ?
                                `NEC_CD_BYP : `NEC_CD_SETUP};
          default: step = (c == NEC_C_CHIP) ? {u1, `NEC_CD_CHIP} :
                                              {a, `NEC_CD_BLOCK};
        endcase
      end
    endcase
  endfunction

  wire [`NEC_AW+`NEC_DW-1:0] nxt = step(cmd_q, BYPASS, idx_q, a_q);
  wire last_wr = (idx_q == len_q - 3'h1);

  // sequencer: one write per cycle, reads wait for rvalid
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= NEC_H_IDLE;
      cmd_q <= NEC_C_READ;
      a_q <= '0;
      idx_q <= '0;
      len_q <= '0;
      we_q <= 1'b0;
      re_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
      CMD_READY <= 1'b0;
      RD_DATA <= '0;
      RD_VALID <= 1'b0;
      BYPASS <= 1'b0;
    end else begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      RD_VALID <= 1'b0;
      case (st_q)
        NEC_H_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            cmd_q <= cmd_in;
            a_q <= CMD_ADDR;
            idx_q <= '0;
            len_q <= seq_len(cmd_in, BYPASS);
            if (cmd_in == NEC_C_READ) begin
              re_q <= 1'b1;
              addr_q <= CMD_ADDR;
              st_q <= NEC_H_RD;
            end else begin
              st_q <= NEC_H_WR;
            end
          end
        end
        NEC_H_WR: begin
          we_q <= 1'b1;
          {addr_q, wd_q} <= nxt;
          idx_q <= idx_q + 3'h1;
          if (last_wr) begin
            st_q <= NEC_H_IDLE;
            if (cmd_q == NEC_C_BYP_ON) BYPASS <= 1'b1;
            if (cmd_q == NEC_C_BYP_OFF) BYPASS <= 1'b0;
          end
        end
        NEC_H_RD: begin
          if (BUS.rvalid) begin
            RD_DATA <= BUS.rdata;
            RD_VALID <= 1'b1;
            st_q <= NEC_H_IDLE;
          end
        end
        default: st_q <= NEC_H_IDLE;
      endcase
    end
  end

  assign BUS.we = we_q;
  assign BUS.re = re_q;
  assign BUS.addr = addr_q;
  assign BUS.wdata = wd_q;
endmodule

// [tb/nec_bus_assertions.sv]
// bus-side assertions for the erase sequencer link
`timescale 1ns/1ps
`include "nec_defs.svh"
module nec_bus_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic re,
  input wire logic [`NEC_AW-1:0] addr,
  input wire logic [`NEC_DW-1:0] wdata,
  input wire logic [`NEC_DW-1:0] rdata,
  input wire logic rvalid
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ****************************************
  // selection window tracker
  // ****************************************
  logic arm_q, win_q, arm_d, win_d, hit_w, keep_w;
  logic [9:0] age_q, age_d;
  // window trusted for 1000 cycles only, well short of its real end
  assign keep_w = wdata == `NEC_CD_UNLK1 || wdata == `NEC_CD_UNLK2;
  assign arm_d = we ? (wdata == `NEC_CD_SETUP || (arm_q && keep_w)) : arm_q;
  assign hit_w = we && wdata == `NEC_CD_BLOCK && (arm_q || win_q);
  assign win_d = hit_w || (win_q && !we && age_q != 10'h3E8);
  assign age_d = hit_w ? 10'h000 : age_q + 10'h001;
  // tracker registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 1'b0;
      win_q <= 1'b0;
      age_q <= 10'h000;
    end else begin
      arm_q <= arm_d;
      win_q <= win_d;
      age_q <= age_d;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_lead;
    !we ##1 we && wdata == `NEC_CD_UNLK1 && addr[11:0] == `NEC_AD_UNLK1;
  endsequence
  sequence s_setup;
    we && wdata == `NEC_CD_SETUP ##1 we && wdata == `NEC_CD_UNLK1;
  endsequence
  sequence s_tail;
    we && wdata == `NEC_CD_UNLK2 ##1
      we && (wdata == `NEC_CD_CHIP || wdata == `NEC_CD_BLOCK);
  endsequence
  property p_rd_answer;
    re |=> rvalid;
  endproperty
  property p_rd_quiet;
    !re |=> !rvalid;
  endproperty
  property p_rd_hold;
    !re |=> $stable(rdata);
  endproperty
  property p_unlock_pair;
    s_lead |=> we && wdata == `NEC_CD_UNLK2 && addr[11:0] == `NEC_AD_UNLK2;
  endproperty
  property p_setup_tail;
    s_setup |=> s_tail;
  endproperty
  property p_bypass_pair;
    !we ##1 we && wdata == `NEC_CD_SETUP
      |=> we && (wdata == `NEC_CD_CHIP || wdata == `NEC_CD_BLOCK);
  endproperty
  property p_suspend_single;
    !we ##1 we && wdata == `NEC_CD_SUSP |=> !we;
  endproperty
  property p_window_poll;
    re && win_q |=> rvalid && !rdata[`NEC_SB_WIN];
  endproperty
  property p_no_clash;
    !(we && re);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read got no answer");
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("answer without read");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  a_unlock_pair: assert property (p_unlock_pair)
    else $error("second unlock write missing");
  a_setup_tail: assert property (p_setup_tail)
    else $error("erase sequence tail wrong");
  a_bypass_pair: assert property (p_bypass_pair)
    else $error("bypass erase second write missing");
  a_suspend_single: assert property (p_suspend_single)
    else $error("suspend not a single write");
  a_window_poll: assert property (p_window_poll)
    else $error("window read not polling");
  a_no_clash: assert property (p_no_clash)
    else $error("write and read together");
endmodule

// [tb/test_nor_erase_command_sequencer.sv]
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
`include "nec_defs.svh"
module test_nor_erase_command_sequencer;
  import nec_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic [`NEC_AW-1:0] cmd_addr = 24'h000000;
  logic [15:0] blk_prot = 16'h0000;
  logic [7:0] array_dq = 8'h5A;
  logic pec_done = 1'b0, pec_fail = 1'b0, pec_halted = 1'b0;
  logic cmd_ready, rd_valid, bypass, pec_start, pec_chip, pec_halt;
  logic pec_resume, busy;
  logic [7:0] rd_data;
  logic [15:0] erase_mask;
  int err_total = 0, checks = 0, starts = 0, resumes = 0, writes = 0;
  // ****************************************
  // clock, parts and event counters
  // ****************************************
  always #20 clk = ~clk;
  nec_bus_if bus (.clk(clk), .rst_b(rst_b));
  nec_host u_nec_host (.CORE_CLK(clk), .RST_B(rst_b), .BUS(bus.host),
    .CMD(cmd), .CMD_ADDR(cmd_addr), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .BYPASS(bypass));
  nec_device u_nec_device (.CORE_CLK(clk), .RST_B(rst_b), .BUS(bus.dev),
    .BLK_PROT(blk_prot), .ARRAY_DQ(array_dq), .PEC_DONE(pec_done),
    .PEC_FAIL(pec_fail), .PEC_HALTED(pec_halted), .PEC_START(pec_start),
    .PEC_CHIP(pec_chip), .PEC_HALT(pec_halt), .PEC_RESUME(pec_resume),
    .ERASE_MASK(erase_mask), .BUSY(busy));
  nec_bus_assertions u_chk (.clk(clk), .rst_b(rst_b), .we(bus.we),
    .re(bus.re), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .rvalid(bus.rvalid));
  // pulses are counted so one-cycle outputs are never missed
  always @(posedge clk) begin
    starts += (pec_start === 1'b1);
    resumes += (pec_resume === 1'b1);
    writes += (bus.we === 1'b1);
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait; a hang counts as a mismatch and closes the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic send(input nec_cmd_e c, input logic [3:0] blk);
    wait_ready();
    cmd = c;
    cmd_addr = {blk, {`NEC_BLK_LSB{1'b0}}};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic issue(input nec_cmd_e c, input logic [3:0] blk);
    send(c, blk);
    cyc(2);
    wait_ready();
    // one more edge so a start or resume pulse reaches its counter
    cyc(1);
  endtask
  task automatic rd(input logic [3:0] blk, output logic [7:0] d);
    int n;
    n = 0;
    send(NEC_C_READ, blk);
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (rd_valid !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    d = rd_data;
  endtask
  task automatic finish_op(input logic fail);
    pec_fail = fail;
    pec_done = ~fail;
    cyc(1);
    pec_fail = 1'b0;
    pec_done = 1'b0;
    cyc(1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_chip();
    logic [7:0] d;
    int s0, w0;
    s0 = starts;
    w0 = writes;
    issue(NEC_C_CHIP, 4'h0);
    chk(writes - w0, 6);
    chk(starts - s0, 1);
    chk({pec_chip, busy, erase_mask}, 18'h3FFFF);
    issue(NEC_C_SUSP, 4'h0);
    chk(pec_halt, 0);
    rd(4'h2, d);
    chk({d[`NEC_SB_DONE], d[`NEC_SB_WIN], d[`NEC_SB_FAIL]}, 3'h2);
    finish_op(1'b0);
    rd(4'h2, d);
    chk({busy, d}, {1'b0, array_dq});
    blk_prot = 16'hFFFF;
    issue(NEC_C_CHIP, 4'h0);
    chk({busy, 8'(starts - s0)}, 9'h001);
    blk_prot = 16'h00FF;
    issue(NEC_C_CHIP, 4'h0);
    chk(erase_mask, 16'hFF00);
    finish_op(1'b1);
    rd(4'hA, d);
    chk({busy, d[`NEC_SB_FAIL]}, 2'h3);
    issue(NEC_C_RESET, 4'h0);
    chk(busy, 0);
    $display("test chip done");
  endtask
  task automatic t_block();
    logic [7:0] d;
    int s0, r0;
    blk_prot = 16'h0000;
    s0 = starts;
    issue(NEC_C_BLOCK, 4'h3);
    rd(4'h3, d);
    chk({busy, erase_mask, d[`NEC_SB_WIN]}, 18'h20010);
    issue(NEC_C_ADD, 4'h5);
    chk(erase_mask, 16'h0028);
    // past where the first selection alone would have started the erase
    cyc(1246);
    chk(starts - s0, 0);
    cyc(20);
    chk(starts - s0, 1);
    rd(4'h3, d);
    chk(d[`NEC_SB_WIN], 1);
    issue(NEC_C_ADD, 4'h7);
    chk(erase_mask, 16'h0028);
    issue(NEC_C_SUSP, 4'h0);
    chk(pec_halt, 1);
    pec_halted = 1'b1;
    cyc(2);
    rd(4'h5, d);
    chk(d[`NEC_SB_DONE], 1);
    rd(4'h9, d);
    chk(d, array_dq);
    r0 = resumes;
    issue(NEC_C_RESUME, 4'h0);
    pec_halted = 1'b0;
    chk({pec_halt, 8'(resumes - r0)}, 9'h001);
    finish_op(1'b0);
    chk(busy, 0);
    $display("test block done");
  endtask
  task automatic t_window();
    logic [7:0] d;
    int s0;
    s0 = starts;
    issue(NEC_C_BLOCK, 4'h2);
    issue(NEC_C_RESET, 4'h0);
    chk(busy, 0);
    issue(NEC_C_BLOCK, 4'h2);
    issue(NEC_C_SUSP, 4'h0);
    rd(4'h2, d);
    chk({busy, d[`NEC_SB_DONE], d[`NEC_SB_WIN]}, 3'h7);
    cyc(1300);
    chk(starts - s0, 0);
    issue(NEC_C_RESUME, 4'h0);
    chk(starts - s0, 1);
    finish_op(1'b1);
    issue(NEC_C_SUSP, 4'h0);
    chk({busy, pec_halt}, 2'h2);
    issue(NEC_C_RESET, 4'h0);
    chk(busy, 0);
    $display("test window done");
  endtask
  task automatic t_bypass();
    int s0, w0;
    blk_prot = 16'h0010;
    issue(NEC_C_BYP_ON, 4'h0);
    chk(bypass, 1);
    s0 = starts;
    w0 = writes;
    issue(NEC_C_CHIP, 4'h0);
    chk(writes - w0, 2);
    chk({starts - s0, erase_mask}, 20'h1FFEF);
    finish_op(1'b0);
    issue(NEC_C_BLOCK, 4'h6);
    chk(writes - w0, 4);
    issue(NEC_C_ADD, 4'h4);
    issue(NEC_C_ADD, 4'h1);
    chk(erase_mask, 16'h0042);
    issue(NEC_C_RESET, 4'h0);
    chk(busy, 0);
    issue(NEC_C_BYP_OFF, 4'h0);
    chk(bypass, 0);
    issue(NEC_C_CHIP, 4'h0);
    rst_b = 1'b0;
    cyc(2);
    chk({busy, pec_chip, erase_mask}, 0);
    rst_b = 1'b1;
    cyc(2);
    $display("test bypass done");
  endtask
  // main sequence
  initial begin
    cyc(12);
    rst_b = 1'b1;
    cyc(2);
    t_chip();
    t_block();
    t_window();
    t_bypass();
    give_verdict();
  end
endmodule
